// ---- src/ofs_pkg.sv ----
package ofs_pkg;
  typedef logic [4:0]  ofs_ch_t;
  typedef logic [9:0]  ofs_flt_cnt_t;
  typedef logic [22:0] ofs_ar_cnt_t;
  typedef enum logic {AR_IDLE, AR_WAIT} ofs_ar_e;
endpackage

// ---- src/ofs_regs.svh ----
`ifndef OFS_REGS_SVH
`define OFS_REGS_SVH

// Register byte offsets
`define OFS_A_QSTAT       8'h00
`define OFS_A_CHSTAT0     8'h04
`define OFS_A_DSTAT       8'h18
`define OFS_A_CHCTL0      8'h20
`define OFS_A_OUTCTL      8'h34
`define OFS_A_MODE        8'h38

// Field positions
`define OFS_QS_CUT_LSB    0
`define OFS_QS_PUMP       5
`define OFS_SUMMARY       7
`define OFS_CS_CUT        0
`define OFS_CS_OUT        1
`define OFS_DS_LOW        0
`define OFS_DS_HIGH       1
`define OFS_CTL_ON        0
`define OFS_OC_EXT        5
`define OFS_MODE_FAIL     0

// Timing, times in ns, clock period in ns
`define OFS_CLK_NS        8
`define OFS_T_OT_NS       5000
`define OFS_T_UVOV_NS     3500
`define OFS_T_PUMP_NS     4000
`define OFS_T_AR_NS       64000000
`define OFS_CYC(t)        (((t) + `OFS_CLK_NS - 1) / `OFS_CLK_NS)
`define OFS_OT_CYC        `OFS_CYC(`OFS_T_OT_NS)
`define OFS_UVOV_CYC      `OFS_CYC(`OFS_T_UVOV_NS)
`define OFS_PUMP_CYC      `OFS_CYC(`OFS_T_PUMP_NS)
`define OFS_AR_CYC        (`OFS_T_AR_NS / `OFS_CLK_NS)

`endif

// ---- src/ofs_supervisor.sv ----
// Summary of operation
// - Channel overtemperature held for filter time switches that output off.
// - After thermal filter time, set cutoff in quick and channel status.
// - Normal mode: thermal-off channel restarts on ON write once cool.
// - Cutoff flag clears after cooling and a read of channel status.
// - Fail mode: thermal-off channel restarts only after a mode change.
// - Supply low held for its filter time switches all outputs off.
// - Supply low sets summary flag and supply-low flag in device status.
// - Normal mode: supply-low outputs stay off until recovery and ON write.
// - Supply-low flag clears after recovery and device status read.
// - Fail mode: supply-low outputs restart automatically.
// - Autorestart interval is 64 ms.
// - Supply high held for filter time sets summary and supply-high flags.
// - Supply-high flag clears after recovery and device status read.
// - Before pump settles outputs stay off; ON commands kept and run later.
// - Pump fault held for its filter time switches all outputs off.
// - Pump fault sets summary flag and pump flag in quick status.
// - Command kept during pump fault runs on recovery with fresh inrush.
// - Pump flag clears after recovery and quick status read.
// - Reverse supply: all outputs on, external drive low, no protection.
`timescale 1ns/1ps
`include "ofs_regs.svh"

module ofs_supervisor #(
  parameter int AR_CYC = `OFS_AR_CYC
) (
  input  wire logic              clk,              // 125 MHz clock
  input  wire logic              rst_b,            // Sync reset, low
  input  wire logic              hsel,             // AHB select
  input  wire logic [7:0]        haddr,            // AHB address
  input  wire logic [1:0]        htrans,           // AHB transfer type
  input  wire logic              hwrite,           // AHB write
  input  wire logic [2:0]        hsize,            // AHB size
  input  wire logic              hready,           // AHB bus ready
  input  wire logic [31:0]       hwdata,           // AHB write data
  output logic [31:0]            hrdata,           // AHB read data
  output logic                   hreadyout,        // AHB slave ready
  output logic                   hresp,            // AHB response
  input  wire ofs_pkg::ofs_ch_t  ot_raw,           // Per channel overtemp
  input  wire logic              uv_raw,           // Supply below limit
  input  wire logic              ov_raw,           // Supply above limit
  input  wire logic              pump_bad_raw,     // Pump out of range
  input  wire logic              pump_settled,     // Pump settled once
  input  wire logic              rev_pol,          // Reverse supply
  output ofs_pkg::ofs_ch_t       out_en,           // Power output gates
  output ofs_pkg::ofs_ch_t       inrush_current_window, // Window start
  output logic                   external_switch_drive_output, // Ext drive
  output logic                   fail_mode         // Fail mode active
);

  // Filter inputs: 0..4 thermal, 5 supply low, 6 supply high, 7 pump
  logic [7:0]                 raw_v;
  logic [7:0]                 flt_r;
  ofs_pkg::ofs_flt_cnt_t      cnt_r [8];
  ofs_pkg::ofs_ch_t           thermal_cutoff_r;
  ofs_pkg::ofs_ch_t           ot_off_r;
  ofs_pkg::ofs_ch_t           uv_off_r;
  ofs_pkg::ofs_ch_t           on_req_r;
  logic                       supply_low_flag_r;
  logic                       supply_high_flag_r;
  logic                       pump_fault_flag_r;
  logic                       device_fault_summary_flag;
  logic                       ext_on_r;
  logic                       fail_r;
  ofs_pkg::ofs_ar_e           ar_state_r;
  ofs_pkg::ofs_ar_cnt_t       ar_cnt_r;
  logic                       ar_fire;
  logic                       pump_blk;
  ofs_pkg::ofs_ch_t           ot_flt;
  ofs_pkg::ofs_ch_t           out_nxt;
  ofs_pkg::ofs_ch_t           out_en_r;
  // Bus side
  logic                       addr_ok;
  logic                       rd_acc;
  logic                       wr_pend_r;
  logic [7:0]                 wr_addr_r;
  logic [31:0]                rd_nxt;
  logic [31:0]                hrdata_r;
  logic                       rd_q;
  logic                       rd_dev;
  ofs_pkg::ofs_ch_t           rd_ch;
  ofs_pkg::ofs_ch_t           on_wr;
  ofs_pkg::ofs_ch_t           on_val;
  logic                       mode_chg;

  function automatic ofs_pkg::ofs_flt_cnt_t flt_limit(input int k);
    if (k < 5) begin
      return ofs_pkg::ofs_flt_cnt_t'(`OFS_OT_CYC);
    end else if (k < 7) begin
      return ofs_pkg::ofs_flt_cnt_t'(`OFS_UVOV_CYC);
    end
    return ofs_pkg::ofs_flt_cnt_t'(`OFS_PUMP_CYC);
  endfunction

  // Channel index of a register bank (status or control), 7 if none
  function automatic logic [2:0] ch_of(input logic [7:0] a,
                                       input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    if (a >= base && d < 8'h14 && d[1:0] == 2'b00) begin
      return d[4:2];
    end
    return 3'h7;
  endfunction

  assign raw_v = {pump_bad_raw, ov_raw, uv_raw, ot_raw};
  assign ot_flt = flt_r[4:0];
  assign pump_blk = flt_r[7] | ~pump_settled;
  assign device_fault_summary_flag = supply_low_flag_r | supply_high_flag_r
                                     | pump_fault_flag_r;

  // Deglitch filters
  for (genvar k = 0; k < 8; k++) begin : g_flt
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        cnt_r[k] <= '0;
        flt_r[k] <= 1'b0;
      end else if (!raw_v[k]) begin
        cnt_r[k] <= '0;
        flt_r[k] <= 1'b0;
      end else if (cnt_r[k] == flt_limit(k) - 10'h001) begin
        flt_r[k] <= 1'b1;
      end else begin
        cnt_r[k] <= cnt_r[k] + 10'h001;
      end
    end
  end

  // Bus address phase
  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_acc  = addr_ok & ~hwrite;
  assign rd_q    = rd_acc && haddr == `OFS_A_QSTAT;
  assign rd_dev  = rd_acc && haddr == `OFS_A_DSTAT;

  always_comb begin
    logic [2:0] c;
    c = ch_of(haddr, `OFS_A_CHSTAT0);
    rd_nxt = 32'h0000_0000;
    for (int i = 0; i < 5; i++) begin
      rd_ch[i] = rd_acc && c == 3'(i);
    end
    case (haddr)
      `OFS_A_QSTAT: begin
        rd_nxt[`OFS_QS_CUT_LSB +: 5] = thermal_cutoff_r;
        rd_nxt[`OFS_QS_PUMP] = pump_fault_flag_r;
        rd_nxt[`OFS_SUMMARY] = device_fault_summary_flag;
      end
      `OFS_A_DSTAT: begin
        rd_nxt[`OFS_DS_LOW]  = supply_low_flag_r;
        rd_nxt[`OFS_DS_HIGH] = supply_high_flag_r;
        rd_nxt[`OFS_SUMMARY] = device_fault_summary_flag;
      end
      `OFS_A_OUTCTL: begin
        rd_nxt[4:0] = on_req_r;
        rd_nxt[`OFS_OC_EXT] = ext_on_r;
      end
      `OFS_A_MODE: begin
        rd_nxt[`OFS_MODE_FAIL] = fail_r;
      end
      default: begin
        if (c != 3'h7) begin
          rd_nxt[`OFS_CS_CUT] = thermal_cutoff_r[c];
          rd_nxt[`OFS_CS_OUT] = out_en_r[c];
          rd_nxt[`OFS_SUMMARY] = device_fault_summary_flag;
        end else if (ch_of(haddr, `OFS_A_CHCTL0) != 3'h7) begin
          rd_nxt[`OFS_CTL_ON] = on_req_r[ch_of(haddr, `OFS_A_CHCTL0)];
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_r <= haddr;
      end
      if (rd_acc) begin
        hrdata_r <= rd_nxt;
      end
    end
  end

  // Zero wait state, always OKAY; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  assign hrdata = hrdata_r;

  // Write data phase decode
  always_comb begin
    logic [2:0] c;
    c = ch_of(wr_addr_r, `OFS_A_CHCTL0);
    on_wr  = '0;
    on_val = '0;
    mode_chg = 1'b0;
    if (wr_pend_r) begin
      if (wr_addr_r == `OFS_A_OUTCTL) begin
        on_wr  = '1;
        on_val = hwdata[4:0];
      end else if (c != 3'h7) begin
        on_wr[c]  = 1'b1;
        on_val[c] = hwdata[`OFS_CTL_ON];
      end
      if (wr_addr_r == `OFS_A_MODE) begin
        mode_chg = hwdata[`OFS_MODE_FAIL] != fail_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      on_req_r <= '0;
      ext_on_r <= 1'b0;
      fail_r   <= 1'b0;
    end else begin
      // Kept while pump blocks, so it runs once the pump is good
      on_req_r <= (on_req_r & ~on_wr) | (on_val & on_wr);
      if (wr_pend_r && wr_addr_r == `OFS_A_OUTCTL) begin
        ext_on_r <= hwdata[`OFS_OC_EXT];
      end
      if (mode_chg) begin
        fail_r <= ~fail_r;
      end
    end
  end

  // Thermal shutdown latches and restart
  for (genvar i = 0; i < 5; i++) begin : g_ch
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        ot_off_r[i] <= 1'b0;
        thermal_cutoff_r[i] <= 1'b0;
      end else begin
        if (ot_flt[i]) begin
          ot_off_r[i] <= 1'b1;
        end else if (!ot_raw[i] && mode_chg) begin
          ot_off_r[i] <= 1'b0;
        end else if (!ot_raw[i] && !fail_r && on_wr[i] && on_val[i]) begin
          ot_off_r[i] <= 1'b0;
        end
        // Set wins over a clearing read
        if (ot_flt[i]) begin
          thermal_cutoff_r[i] <= 1'b1;
        end else if (rd_ch[i] && !ot_raw[i]) begin
          thermal_cutoff_r[i] <= 1'b0;
        end
      end
    end
  end

  // Supply low restart, by write in Normal mode or by autorestart
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      uv_off_r <= '0;
    end else if (flt_r[5]) begin
      uv_off_r <= '1;
    end else if (!uv_raw && ar_fire) begin
      uv_off_r <= '0;
    end else if (!uv_raw && !fail_r) begin
      uv_off_r <= uv_off_r & ~(on_wr & on_val);
    end
  end

  // Autorestart retries every interval while supply-low outputs are held off in Fail mode
  assign ar_fire = ar_state_r == ofs_pkg::AR_WAIT
                   && ar_cnt_r == ofs_pkg::ofs_ar_cnt_t'(AR_CYC - 1);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ar_state_r <= ofs_pkg::AR_IDLE;
      ar_cnt_r   <= '0;
    end else begin
      case (ar_state_r)
        ofs_pkg::AR_IDLE: begin
          ar_cnt_r <= '0;
          if (fail_r && |uv_off_r) begin
            ar_state_r <= ofs_pkg::AR_WAIT;
          end
        end
        ofs_pkg::AR_WAIT: begin
          if (!fail_r || uv_off_r == '0) begin
            ar_state_r <= ofs_pkg::AR_IDLE;
          end else if (ar_fire) begin
            ar_cnt_r <= '0;
          end else begin
            ar_cnt_r <= ar_cnt_r + 23'h000001;
          end
        end
        default: begin
          ar_state_r <= ofs_pkg::AR_IDLE;
        end
      endcase
    end
  end

  // Device-level flags; a fresh event wins over a clearing read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      supply_low_flag_r  <= 1'b0;
      supply_high_flag_r <= 1'b0;
      pump_fault_flag_r  <= 1'b0;
    end else begin
      if (flt_r[5]) begin
        supply_low_flag_r <= 1'b1;
      end else if (rd_dev && !uv_raw) begin
        supply_low_flag_r <= 1'b0;
      end
      if (flt_r[6]) begin
        supply_high_flag_r <= 1'b1;
      end else if (rd_dev && !ov_raw) begin
        supply_high_flag_r <= 1'b0;
      end
      if (flt_r[7]) begin
        pump_fault_flag_r <= 1'b1;
      end else if (rd_q && !pump_bad_raw) begin
        pump_fault_flag_r <= 1'b0;
      end
    end
  end

  // Filter outputs cut the gate in the same cycle the latch is set
  always_comb begin
    if (rev_pol) begin
      out_nxt = '1;
    end else begin
      out_nxt = on_req_r & ~ot_off_r & ~uv_off_r & ~ot_flt
                & ~{5{flt_r[5]}} & ~{5{pump_blk}};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_en_r <= '0;
      inrush_current_window <= '0;
      external_switch_drive_output <= 1'b0;
      fail_mode <= 1'b0;
    end else begin
      out_en_r <= out_nxt;
      // No inrush profile while reverse protection forces gates on
      inrush_current_window <= out_nxt & ~out_en_r & ~{5{rev_pol}};
      external_switch_drive_output <= ext_on_r & ~rev_pol;
      fail_mode <= fail_r;
    end
  end
  assign out_en = out_en_r;

  sequence s_pump_back;
    pump_blk ##1 !pump_blk;
  endsequence

  sequence s_uv_rise;
    !flt_r[5] ##1 flt_r[5];
  endsequence

  for (genvar i = 0; i < 5; i++) begin : g_chk
    property p_ot_cut;
      @(posedge clk) disable iff (!rst_b)
      ot_flt[i] && !rev_pol |=> !out_en_r[i];
    endproperty
    a_ot_cut: assert property (p_ot_cut)
      else $error("thermal fault left output on");

    property p_ot_flag;
      @(posedge clk) disable iff (!rst_b)
      $rose(ot_flt[i]) |=> thermal_cutoff_r[i];
    endproperty
    a_ot_flag: assert property (p_ot_flag)
      else $error("thermal cutoff flag not set");

    // A read while still hot must not drop the flag
    property p_ot_hold;
      @(posedge clk) disable iff (!rst_b)
      thermal_cutoff_r[i] && ot_raw[i] |=> thermal_cutoff_r[i];
    endproperty
    a_ot_hold: assert property (p_ot_hold)
      else $error("thermal cutoff cleared while still hot");

    property p_ot_fail;
      @(posedge clk) disable iff (!rst_b)
      ot_off_r[i] && fail_r && !mode_chg && !ot_flt[i] |=> ot_off_r[i];
    endproperty
    a_ot_fail: assert property (p_ot_fail)
      else $error("thermal restart in fail mode without mode change");

    property p_filter_restart;
      @(posedge clk) disable iff (!rst_b)
      !ot_raw[i] |=> cnt_r[i] == 10'h000 && !ot_flt[i];
    endproperty
    a_filter_restart: assert property (p_filter_restart)
      else $error("filter did not restart on drop");

    property p_inrush_fresh;
      @(posedge clk) disable iff (!rst_b)
      s_pump_back ##0 (on_req_r[i] && !ot_off_r[i] && !uv_off_r[i]
        && !ot_flt[i] && !flt_r[5] && !rev_pol && !out_en_r[i])
        |=> inrush_current_window[i] && out_en_r[i];
    endproperty
    a_inrush_fresh: assert property (p_inrush_fresh)
      else $error("held command not run after pump recovery");
  end

  property p_uv_all_off;
    @(posedge clk) disable iff (!rst_b)
    s_uv_rise ##0 !rev_pol |=> out_en_r == 5'h00 && supply_low_flag_r
      && device_fault_summary_flag;
  endproperty
  a_uv_all_off: assert property (p_uv_all_off)
    else $error("supply low did not cut outputs and set flags");

  property p_ov_flag;
    @(posedge clk) disable iff (!rst_b)
    flt_r[6] |=> supply_high_flag_r && device_fault_summary_flag;
  endproperty
  a_ov_flag: assert property (p_ov_flag)
    else $error("supply high flag missing");

  property p_pump_off;
    @(posedge clk) disable iff (!rst_b)
    pump_blk && !rev_pol |=> out_en_r == 5'h00;
  endproperty
  a_pump_off: assert property (p_pump_off)
    else $error("output on while pump invalid");

  property p_pump_flag;
    @(posedge clk) disable iff (!rst_b)
    $rose(flt_r[7]) |=> pump_fault_flag_r && device_fault_summary_flag;
  endproperty
  a_pump_flag: assert property (p_pump_flag)
    else $error("pump fault flag not set");

  property p_read_clear;
    @(posedge clk) disable iff (!rst_b)
    rd_dev && !uv_raw && !flt_r[5] |=> !supply_low_flag_r;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("supply low flag kept after clearing read");

  property p_rev;
    @(posedge clk) disable iff (!rst_b)
    rev_pol |=> out_en_r == 5'h1F && !external_switch_drive_output;
  endproperty
  a_rev: assert property (p_rev)
    else $error("reverse supply handling wrong");

  property p_ar_period;
    @(posedge clk) disable iff (!rst_b)
    ar_fire && !uv_raw && !flt_r[5] |=> uv_off_r == 5'h00;
  endproperty
  a_ar_period: assert property (p_ar_period)
    else $error("autorestart did not release supply-low outputs");

endmodule

// ---- verification/ofs_host_model.sv ----
`timescale 1ns/1ps

module ofs_host_model (
  input  wire logic        clk,     // Bus clock
  input  wire logic        hready,  // Bus ready
  input  wire logic [31:0] hrdata,  // Slave read data
  output logic             hsel,    // Slave select
  output logic [7:0]       haddr,   // Byte address
  output logic [1:0]       htrans,  // Transfer type
  output logic             hwrite,  // Write strobe
  output logic [2:0]       hsize,   // Always one word
  output logic [31:0]      hwdata,  // Write data
  output logic             rd_done, // One cycle when a read ends
  output logic [31:0]      rd_val   // Data taken by that read
);
  initial begin
    hsel    = 1'h0;
    haddr   = 8'h00;
    htrans  = 2'h0;
    hwrite  = 1'h0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    rd_done = 1'h0;
    rd_val  = 32'h0;
  end

  always @(posedge clk) begin
    if (rd_done) begin
      rd_done <= 1'h0;
    end
  end

  // Released address and data lines carry inverted values so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    haddr  <= ~a;
    hwdata <= w ? d : ~hwdata;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    hwdata <= ~d;
    if (!w) begin
      rd_val  <= hrdata;
      rd_done <= 1'h1;
    end
  endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "ofs_regs.svh"

module tb_top;
  localparam int AR = 50;
  localparam int OT = `OFS_OT_CYC;
  localparam int UO = `OFS_UVOV_CYC;
  logic             clk = 1'h0;
  logic             rst_b = 1'h0;
  logic             hsel, hwrite, hreadyout, hresp, rd_done;
  logic [7:0]       haddr;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      hwdata, hrdata, rd_val;
  ofs_pkg::ofs_ch_t ot_raw = 5'h00;
  logic             uv_raw = 1'h0;
  logic             ov_raw = 1'h0;
  logic             pump_bad_raw = 1'h0;
  logic             pump_settled = 1'h0;
  logic             rev_pol = 1'h0;
  ofs_pkg::ofs_ch_t out_en, inrush_current_window;
  logic             ext_drv, fail_mode;
  logic [31:0]      exp_q[$];
  int               n_fail = 0;
  int               check_count = 0;
  int               n_inrush = 0;
  int               n0;

  always #4 clk = ~clk;

  ofs_supervisor #(.AR_CYC(AR)) dut_u (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ot_raw(ot_raw),
    .uv_raw(uv_raw), .ov_raw(ov_raw), .pump_bad_raw(pump_bad_raw),
    .pump_settled(pump_settled), .rev_pol(rev_pol), .out_en(out_en),
    .inrush_current_window(inrush_current_window),
    .external_switch_drive_output(ext_drv), .fail_mode(fail_mode)
  );

  ofs_host_model host_u (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .rd_done(rd_done), .rd_val(rd_val)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host_u.xfer(1'h0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'h1, a, d);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic oe(input logic [4:0] e);
    @(negedge clk);
    chk({27'h0, out_en}, {27'h0, e});
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Each finished read is matched against the oldest noted value
  always @(posedge clk) begin
    if (rd_done === 1'h1) begin
      chk(rd_val, exp_q.pop_front());
    end
  end

  always @(posedge clk) begin
    n_inrush <= n_inrush + $countones(inrush_current_window);
  end

  initial begin
    cyc(30000);
    n_fail++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h42C020A7));
    cyc(12);
    rst_b <= 1'h1;
    @(posedge clk);
    oe(5'h00);
    chk({31'h0, hreadyout}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    rd(`OFS_A_QSTAT, 32'h0);
    wr(8'h3C, $urandom());
    rd(8'h3C, 32'h0);
    // Commands before the pump settles are kept, not dropped
    wr(`OFS_A_OUTCTL, 32'h3F);
    cyc(3);
    oe(5'h00);
    @(posedge clk);
    n0 = n_inrush;
    pump_settled <= 1'h1;
    cyc(3);
    oe(5'h1F);
    chk(n_inrush - n0, 32'h5);
    chk({31'h0, ext_drv}, 32'h1);
    @(posedge clk);
    // A drop of one cycle must restart the deglitch count
    ot_raw <= 5'h04;
    cyc($urandom_range(OT - 2, 1));
    ot_raw <= 5'h00;
    cyc(1);
    ot_raw <= 5'h04;
    cyc(OT - 3);
    oe(5'h1F);
    cyc(6);
    oe(5'h1B);
    rd(`OFS_A_QSTAT, 32'h04);
    rd(`OFS_A_CHSTAT0 + 8'h08, 32'h01);
    wr(`OFS_A_CHCTL0 + 8'h08, 32'h1);
    cyc(2);
    oe(5'h1B);
    @(posedge clk);
    ot_raw <= 5'h00;
    rd(`OFS_A_CHSTAT0 + 8'h08, 32'h01);
    rd(`OFS_A_CHSTAT0 + 8'h08, 32'h00);
    wr(`OFS_A_CHCTL0 + 8'h08, 32'h1);
    cyc(2);
    oe(5'h1F);
    @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) uv_raw <= 1'h1;
      else ov_raw <= 1'h1;
      cyc(UO + 6);
      if (k == 0) begin
        oe(5'h00);
        wr(`OFS_A_OUTCTL, 32'h3F);
        cyc(2);
        oe(5'h00);
      end
      rd(`OFS_A_DSTAT, 32'h80 | (32'h1 << k));
      rd(`OFS_A_QSTAT, 32'h80);
      uv_raw <= 1'h0;
      ov_raw <= 1'h0;
      cyc(3);
      if (k == 0) oe(5'h00);
      wr(`OFS_A_OUTCTL, 32'h3F);
      cyc(2);
      oe(5'h1F);
      rd(`OFS_A_DSTAT, 32'h80 | (32'h1 << k));
      rd(`OFS_A_DSTAT, 32'h0);
    end
    pump_bad_raw <= 1'h1;
    cyc(`OFS_PUMP_CYC + 6);
    oe(5'h00);
    rd(`OFS_A_QSTAT, 32'hA0);
    wr(`OFS_A_OUTCTL, 32'h3F);
    n0 = n_inrush;
    pump_bad_raw <= 1'h0;
    cyc(3);
    oe(5'h1F);
    chk(n_inrush - n0, 32'h5);
    rd(`OFS_A_QSTAT, 32'hA0);
    rd(`OFS_A_QSTAT, 32'h0);
    wr(`OFS_A_MODE, 32'h1);
    ot_raw <= 5'h01;
    cyc(OT + 6);
    ot_raw <= 5'h00;
    wr(`OFS_A_CHCTL0, 32'h1);
    cyc(2);
    oe(5'h1E);
    chk({31'h0, fail_mode}, 32'h1);
    rd(`OFS_A_CHSTAT0, 32'h01);
    wr(`OFS_A_MODE, 32'h0);
    cyc(2);
    oe(5'h1F);
    wr(`OFS_A_MODE, 32'h1);
    uv_raw <= 1'h1;
    cyc(UO + 6);
    oe(5'h00);
    @(posedge clk);
    uv_raw <= 1'h0;
    cyc(AR + 6);
    oe(5'h1F);
    rd(`OFS_A_DSTAT, 32'h81);
    rd(`OFS_A_DSTAT, 32'h0);
    rd(`OFS_A_CHCTL0 + 8'h10, 32'h1);
    wr(`OFS_A_OUTCTL, 32'h20);
    rd(`OFS_A_OUTCTL, 32'h20);
    rd(`OFS_A_MODE, 32'h1);
    rev_pol <= 1'h1;
    cyc(3);
    oe(5'h1F);
    chk({31'h0, ext_drv}, 32'h0);
    @(posedge clk);
    rev_pol <= 1'h0;
    cyc(4);
    stop_test();
  end
endmodule
